// file: verilog/lcp_defines.svh
`ifndef LCP_DEFINES_SVH
`define LCP_DEFINES_SVH


// ***********************************
// register offsets
// ***********************************
`define LCP_ADDR_CSUM0 16'h05A0
`define LCP_ADDR_CSUM1 16'h05A1
`define LCP_ADDR_CSUM2 16'h05A2
`define LCP_ADDR_CSUM3 16'h05A3
`define LCP_ADDR_PD 16'h05B0

// ***********************************
// reset values
// ***********************************
`define LCP_RST_CSUM0 8'hC3
`define LCP_RST_CSUM1 8'hC4
`define LCP_RST_CSUM2 8'hC5
`define LCP_RST_CSUM3 8'hC6
`define LCP_RST_PD 8'h00
`define LCP_RDATA_IDLE 8'h00

// ***********************************
// widths
// ***********************************
`define LCP_ADDR_W 16
`define LCP_DATA_W 8
`define LCP_LID_W 5

`endif

// file: verilog/lcp_pkg.sv
`include "lcp_defines.svh"

package lcp_pkg;

   typedef logic [`LCP_DATA_W-1:0] lcp_byte_t;
   typedef logic [`LCP_ADDR_W-1:0] lcp_addr_t;

   typedef enum logic [2:0] {
      LCP_SEL_NONE,
      LCP_SEL_CSUM0,
      LCP_SEL_CSUM1,
      LCP_SEL_CSUM2,
      LCP_SEL_CSUM3,
      LCP_SEL_PD
   } lcp_sel_e;

   // shared by the read and write paths
   function automatic lcp_sel_e lcp_decode(input lcp_addr_t addr);
      lcp_sel_e sel;
      sel = LCP_SEL_NONE;
      if (addr == `LCP_ADDR_CSUM0) begin
         sel = LCP_SEL_CSUM0;
      end else if (addr == `LCP_ADDR_CSUM1) begin
         sel = LCP_SEL_CSUM1;
      end else if (addr == `LCP_ADDR_CSUM2) begin
         sel = LCP_SEL_CSUM2;
      end else if (addr == `LCP_ADDR_CSUM3) begin
         sel = LCP_SEL_CSUM3;
      end else if (addr == `LCP_ADDR_PD) begin
         sel = LCP_SEL_PD;
      end
      return sel;
   endfunction

endpackage

// file: verilog/lcp_lane_csum.sv
`include "lcp_defines.svh"

module lcp_lane_csum #(
   parameter logic [7:0] RST_VAL = `LCP_RST_CSUM0
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // link configuration fields
   input wire logic [7:0] did,
   input wire logic [3:0] bid,
   input wire logic [4:0] lid,
   input wire logic scr,
   input wire logic [4:0] l_m1,
   input wire logic [7:0] f_m1,
   input wire logic [4:0] k_m1,
   input wire logic [7:0] m_m1,
   input wire logic [1:0] cs,
   input wire logic [4:0] n_m1,
   input wire logic [2:0] subclassv,
   input wire logic [4:0] np_m1,
   input wire logic [2:0] jesdv,
   input wire logic [4:0] s_m1,
   input wire logic hd,
   input wire logic [4:0] cf,
   // checksum
   output lcp_pkg::lcp_byte_t csum
);
   import lcp_pkg::*;

   lcp_byte_t csum_reg;
   lcp_byte_t csum_next;

   // 8-bit adds wrap, which is the modulo 256 itself
   always_comb begin
      csum_next = did + 8'(bid) + 8'(lid) + 8'(scr) + 8'(l_m1) + f_m1 + 8'(k_m1)
         + m_m1 + 8'(cs) + 8'(n_m1) + 8'(subclassv) + 8'(np_m1) + 8'(jesdv)
         + 8'(s_m1) + 8'(hd) + 8'(cf);
   end

   // recomputed every cycle, never loaded from the bus
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         csum_reg <= RST_VAL;
      end else begin
         csum_reg <= csum_next;
      end
   end

   assign csum = csum_reg;

endmodule

// file: verilog/lcp_pd_ctrl.sv
`include "lcp_defines.svh"

module lcp_pd_ctrl #(
   parameter int NUM_LANES = 8
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // write port
   input wire logic wr_en,
   input wire logic [NUM_LANES-1:0] wdata,
   // lane control
   output logic [NUM_LANES-1:0] lane_pd
);
   import lcp_pkg::*;

   logic [NUM_LANES-1:0] pd_reg;
   logic [NUM_LANES-1:0] pd_next;

   always_comb begin
      pd_next = pd_reg;
      if (wr_en) begin
         pd_next = wdata;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         pd_reg <= NUM_LANES'(`LCP_RST_PD);
      end else begin
         pd_reg <= pd_next;
      end
   end

   assign lane_pd = pd_reg;

endmodule

// file: verilog/lcp_top.sv
`include "lcp_defines.svh"

module lcp_top #(
   parameter int NUM_CSUM_LANES = 4,
   parameter int NUM_PHY_LANES = 8
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // register port
   input wire lcp_pkg::lcp_addr_t reg_addr,
   input wire lcp_pkg::lcp_byte_t reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output lcp_pkg::lcp_byte_t reg_rdata,
   // link configuration fields, common to all lanes
   input wire logic [7:0] cfg_did,
   input wire logic [3:0] cfg_bid,
   input wire logic cfg_scr,
   input wire logic [4:0] cfg_l_m1,
   input wire logic [7:0] cfg_f_m1,
   input wire logic [4:0] cfg_k_m1,
   input wire logic [7:0] cfg_m_m1,
   input wire logic [1:0] cfg_cs,
   input wire logic [4:0] cfg_n_m1,
   input wire logic [2:0] cfg_subclassv,
   input wire logic [4:0] cfg_np_m1,
   input wire logic [2:0] cfg_jesdv,
   input wire logic [4:0] cfg_s_m1,
   input wire logic cfg_hd,
   input wire logic [4:0] cfg_control_words_per_frame,
   // per-lane identifiers, lane i at bits [5*i+4:5*i]
   input wire logic [NUM_CSUM_LANES*`LCP_LID_W-1:0] cfg_lane_id,
   // serial lane control
   output logic [NUM_PHY_LANES-1:0] serial_lane_output_pair_pd
);
   import lcp_pkg::*;

   // ***********************************
   // checksums
   // ***********************************
   lcp_byte_t csum [NUM_CSUM_LANES];

   for (genvar i = 0; i < NUM_CSUM_LANES; i++) begin : g_csum
      localparam logic [7:0] RST_VAL = (i == 0) ? `LCP_RST_CSUM0 :
         (i == 1) ? `LCP_RST_CSUM1 : (i == 2) ? `LCP_RST_CSUM2 : `LCP_RST_CSUM3;
      lcp_lane_csum #(
         .RST_VAL(RST_VAL)
      ) u_csum (
         .clk(clk),
         .rst_b(rst_b),
         .did(cfg_did),
         .bid(cfg_bid),
         .lid(cfg_lane_id[i*`LCP_LID_W +: `LCP_LID_W]),
         .scr(cfg_scr),
         .l_m1(cfg_l_m1),
         .f_m1(cfg_f_m1),
         .k_m1(cfg_k_m1),
         .m_m1(cfg_m_m1),
         .cs(cfg_cs),
         .n_m1(cfg_n_m1),
         .subclassv(cfg_subclassv),
         .np_m1(cfg_np_m1),
         .jesdv(cfg_jesdv),
         .s_m1(cfg_s_m1),
         .hd(cfg_hd),
         .cf(cfg_control_words_per_frame),
         .csum(csum[i])
      );
   end

   // ***********************************
   // write decode
   // ***********************************
   lcp_sel_e wr_sel;
   logic pd_wr;

   // checksum addresses decode but have no write path
   always_comb begin
      wr_sel = lcp_decode(reg_addr);
      pd_wr = reg_wr && (wr_sel == LCP_SEL_PD);
   end

   lcp_pd_ctrl #(
      .NUM_LANES(NUM_PHY_LANES)
   ) u_pd (
      .clk(clk),
      .rst_b(rst_b),
      .wr_en(pd_wr),
      .wdata(reg_wdata[NUM_PHY_LANES-1:0]),
      .lane_pd(serial_lane_output_pair_pd)
   );

   // ***********************************
   // read path
   // ***********************************
   lcp_byte_t rdata_reg;
   lcp_byte_t rdata_next;

   // data stands only in the cycle after the strobe, zero otherwise
   always_comb begin
      rdata_next = `LCP_RDATA_IDLE;
      if (reg_rd) begin
         case (lcp_decode(reg_addr))
            LCP_SEL_CSUM0: rdata_next = csum[0];
            LCP_SEL_CSUM1: rdata_next = csum[1];
            LCP_SEL_CSUM2: rdata_next = csum[2];
            LCP_SEL_CSUM3: rdata_next = csum[3];
            LCP_SEL_PD: rdata_next = 8'(serial_lane_output_pair_pd);
            default: rdata_next = `LCP_RDATA_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         rdata_reg <= `LCP_RDATA_IDLE;
      end else begin
         rdata_reg <= rdata_next;
      end
   end

   assign reg_rdata = rdata_reg;

endmodule

// file: dv/lcp_lane_rx.sv
module lcp_lane_rx (
   // lane control from the block
   input wire logic [7:0] lane_pd,
   // lanes the receiver still hears
   output logic [7:0] lane_up
);
   timeunit 1ns;
   timeprecision 1ps;
   // a forced-down lane stops sending, so the receiver loses it at once
   assign lane_up = ~lane_pd;
endmodule

// file: dv/lcp_top_assertions.sv
`include "lcp_defines.svh"

module lcp_top_assertions #(
   parameter int NUM_CSUM_LANES = 4,
   parameter int NUM_PHY_LANES = 8
) (
   // clock, reset, register port and the one-bit link fields cfg_scr, cfg_hd
   input wire logic clk, rst_b, reg_wr, reg_rd, cfg_scr, cfg_hd,
   input wire lcp_pkg::lcp_addr_t reg_addr,
   input wire lcp_pkg::lcp_byte_t reg_wdata, reg_rdata,
   // link configuration fields
   input wire logic [7:0] cfg_did, cfg_f_m1, cfg_m_m1,
   input wire logic [4:0] cfg_l_m1, cfg_k_m1, cfg_n_m1, cfg_np_m1, cfg_s_m1,
   input wire logic [4:0] cfg_control_words_per_frame,
   input wire logic [3:0] cfg_bid,
   input wire logic [2:0] cfg_subclassv, cfg_jesdv,
   input wire logic [1:0] cfg_cs,
   input wire logic [NUM_CSUM_LANES*`LCP_LID_W-1:0] cfg_lane_id,
   // lane control
   input wire logic [NUM_PHY_LANES-1:0] serial_lane_output_pair_pd
);
   import lcp_pkg::*;
   logic [7:0] base, exp_sel;
   logic csum_hit, pd_hit;
   // 8-bit target width gives the mod 256 wrap
   assign base = cfg_did + cfg_bid + cfg_scr + cfg_l_m1 + cfg_f_m1 + cfg_k_m1 + cfg_m_m1
      + cfg_cs + cfg_n_m1 + cfg_subclassv + cfg_np_m1 + cfg_jesdv + cfg_s_m1 + cfg_hd
      + cfg_control_words_per_frame;
   assign exp_sel = base + cfg_lane_id[5*reg_addr[1:0]+:5];
   assign csum_hit = (reg_addr & 16'hFFFC) == `LCP_ADDR_CSUM0;
   assign pd_hit = reg_addr == `LCP_ADDR_PD;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   // config must be settled a cycle ahead, the sum is registered
   csum_read_a: assert property (reg_rd && csum_hit && $stable(base)
      && $stable(cfg_lane_id) && $past(rst_b) |=> reg_rdata == $past(exp_sel))
      else $error("checksum read wrong");
   pd_write_a: assert property (reg_wr && pd_hit
      |=> serial_lane_output_pair_pd == $past(reg_wdata)) else $error("pd write lost");
   pd_hold_a: assert property (!(reg_wr && pd_hit)
      |=> $stable(serial_lane_output_pair_pd)) else $error("pd changed unasked");
   pd_keep_a: assert property (reg_wr && pd_hit ##1 !reg_wr [*3]
      |-> serial_lane_output_pair_pd == $past(reg_wdata, 3)) else $error("pd not kept");
   rst_clear_a: assert property ($rose(rst_b)
      |-> serial_lane_output_pair_pd == '0 && reg_rdata == 8'h00) else $error("reset state");
   rd_idle_a: assert property (!reg_rd |=> reg_rdata == 8'h00) else $error("rdata not idle");
   pd_read_a: assert property (reg_rd && pd_hit
      |=> reg_rdata == $past(serial_lane_output_pair_pd)) else $error("pd readback");
   unmapped_rd_a: assert property (reg_rd && !csum_hit && !pd_hit
      |=> reg_rdata == 8'h00) else $error("unmapped read");
   cover property (reg_wr && pd_hit);
   cover property (reg_rd && csum_hit);
   cover property (reg_rd && !csum_hit && !pd_hit);
endmodule

bind lcp_top lcp_top_assertions #(.NUM_CSUM_LANES(NUM_CSUM_LANES),
   .NUM_PHY_LANES(NUM_PHY_LANES)) i_chk (.*);

// file: dv/lane_checksum_and_powerdown_test.sv
`include "lcp_defines.svh"

module lane_checksum_and_powerdown_test;
   timeunit 1ns;
   timeprecision 1ps;
   import lcp_pkg::*;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   lcp_addr_t reg_addr = '0;
   lcp_byte_t reg_wdata = '0;
   lcp_byte_t reg_rdata, d;
   logic [7:0] serial_lane_output_pair_pd, lane_up;
   logic [87:0] cfg_v = 88'h12_3456_789A_BCDE_F013_5724;
   wire logic [7:0] cfg_did, cfg_f_m1, cfg_m_m1;
   wire logic [4:0] cfg_l_m1, cfg_k_m1, cfg_n_m1, cfg_np_m1, cfg_s_m1;
   wire logic [4:0] cfg_control_words_per_frame;
   wire logic [3:0] cfg_bid;
   wire logic [2:0] cfg_subclassv, cfg_jesdv;
   wire logic [1:0] cfg_cs;
   wire logic cfg_scr, cfg_hd;
   wire logic [19:0] cfg_lane_id;
   int n_errors = 0;
   int compares = 0;
   assign {cfg_did, cfg_bid, cfg_scr, cfg_l_m1, cfg_f_m1, cfg_k_m1, cfg_m_m1, cfg_cs,
      cfg_n_m1, cfg_subclassv, cfg_np_m1, cfg_jesdv, cfg_s_m1, cfg_hd,
      cfg_control_words_per_frame, cfg_lane_id} = cfg_v;
   lcp_top i_dut (.*);
   lcp_lane_rx i_rx (.lane_pd(serial_lane_output_pair_pd), .lane_up(lane_up));
   initial forever #20 clk = ~clk;
   initial begin
      #50us;
      n_errors++;
      conclude();
   end
   function automatic lcp_byte_t esum(input int i);
      return 8'(cfg_did + cfg_bid + cfg_scr + cfg_l_m1 + cfg_f_m1 + cfg_k_m1 + cfg_m_m1
         + cfg_cs + cfg_n_m1 + cfg_subclassv + cfg_np_m1 + cfg_jesdv + cfg_s_m1 + cfg_hd
         + cfg_control_words_per_frame + cfg_lane_id[5*i+:5]);
   endfunction
   task chk(input lcp_byte_t got, input lcp_byte_t exp, input string m);
      compares++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch %0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask
   task wr8(input lcp_addr_t a, input lcp_byte_t v);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= v;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task rd8(input lcp_addr_t a);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask
   task csum_all;
      for (int i = 0; i < 4; i++) begin
         rd8(`LCP_ADDR_CSUM0 + i);
         chk(d, esum(i), "checksum");
         wr8(`LCP_ADDR_CSUM0 + i, ~d);
         rd8(`LCP_ADDR_CSUM0 + i);
         chk(d, esum(i), "checksum after write");
      end
   endtask
   task conclude;
      $display("errors %0d compares %0d", n_errors, compares);
      if (n_errors == 0 && compares > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   initial begin
      repeat (2) @(posedge clk);
      rst_b <= 1'b1;
      rd8(`LCP_ADDR_PD);
      chk(d, 8'h00, "pd reset");
      csum_all();
      // all-ones fields force the 8-bit wrap, read at once after the change
      @(posedge clk);
      cfg_v <= '1;
      csum_all();
      for (int i = 0; i < 8; i++) begin
         wr8(`LCP_ADDR_PD, 8'h01 << i);
         #1 chk(serial_lane_output_pair_pd, 8'h01 << i, "lane pd");
         chk(lane_up, ~(8'h01 << i), "lane seen by receiver");
         rd8(`LCP_ADDR_PD);
         chk(d, 8'h01 << i, "pd readback");
      end
      wr8(16'h05B1, 8'hFF);
      rd8(16'h05A4);
      chk(d, 8'h00, "unmapped read");
      rd8(`LCP_ADDR_PD);
      chk(d, 8'h80, "pd after unmapped write");
      wr8(`LCP_ADDR_PD, 8'hA5);
      rst_b <= 1'b0;
      repeat (2) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      #1 chk(serial_lane_output_pair_pd, 8'h00, "pd after reset");
      conclude();
   end
endmodule
